// ===== pkg/core_consts.svh
// constants of the 8-bit harvard core: timing, sfr addresses, flag bits
// assumes the includer compiles core_pkg first
`ifndef CORE_CONSTS_SVH
`define CORE_CONSTS_SVH
`define CLK_PERIOD_NS 5
`define INSTR_CYCLE_NS 200
`define INSTR_CYCLES (`INSTR_CYCLE_NS / `CLK_PERIOD_NS)
`define PC_RESET 11'h000
`define W_RESET 8'h00
`define FSR_RESET 8'h00
`define PCLATH_RESET 8'h00
`define FLAGS_RESET 3'h0
`define ADDR_INDF 7'h00
`define ADDR_PCL 7'h02
`define ADDR_STATUS 7'h03
`define ADDR_FSR 7'h04
`define ADDR_PCLATH 7'h0a
`define FLAG_C 0
`define FLAG_NC 1
`define FLAG_Z 2
`define PROG_WORD_BITS 14
`endif

// ===== pkg/core_pkg.sv
// types shared by the core: instruction classes, alu ops, states, carriers
// assumes nothing beyond a systemverilog compiler
package core_pkg;
  typedef enum logic [1:0] {
    IC_FILE = 2'h0, IC_LIT = 2'h1, IC_GOTO = 2'h2, IC_BIT = 2'h3
  } iclass_t;
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_IOR = 4'h3,
    OP_XOR = 4'h4, OP_MOV = 4'h5, OP_COM = 4'h6, OP_INC = 4'h7,
    OP_DEC = 4'h8, OP_RLF = 4'h9, OP_RRF = 4'ha, OP_SWAP = 4'hb,
    OP_CLR = 4'hc, OP_MOVW = 4'hd, OP_RSV0 = 4'he, OP_RSV1 = 4'hf
  } alu_op_t;
  typedef enum logic [3:0] {
    S_FILL = 4'h1, S_RUN = 4'h2, S_FLUSH = 4'h4, S_PROG = 4'h8
  } core_state_t;
  typedef struct packed {
    logic [7:0] val;
    logic c;
    logic nc;
    logic upd_c;
    logic upd_nc;
    logic upd_z;
  } alu_res_t;
  typedef struct packed {
    logic mode;
    logic clk;
    logic data;
  } prog_pins_t;
endpackage

// ===== rtl/harvard_core.sv
// execution datapath of a small 8-bit harvard core with serial programming
// assumes a combinational program memory read: PM_DATA follows PM_ADDR
//
// Behaviour
// - one 14-bit word fetched per instruction cycle
// - next word fetched while current one executes
// - non-branch instructions take one 200 ns cycle
// - branches take two cycles, fetched word discarded
// - pc addresses up to 2K on-chip words only
// - 8-bit alu: add, subtract, shift, logic ops
// - two operands: w with file or literal
// - single operand: w or a file register
// - w is 8-bit, unaddressed, alu operand/destination
// - alu updates carry, nibble carry, zero flags
// - subtraction flags report inverted borrow (carry out set when no borrow)
// - sfrs incl pc in data map, indirect too
// - programming clock and data on two pins
`include "core_consts.svh"
module harvard_core #(
  parameter int PROG_DEPTH = 2048
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  output logic [10:0] PM_ADDR,
  input wire logic [13:0] PM_DATA,
  output logic INSTR_STEP,
  output logic [7:0] W_VALUE,
  output logic [2:0] FLAGS,
  input wire logic PROG_MODE,
  input wire logic PROG_CLOCK_PIN,
  input wire logic PROG_DATA_PIN_I,
  output logic PROG_DATA_PIN_O,
  output logic PROG_DATA_PIN_OE_N,
  output logic PROG_WR,
  output logic [10:0] PROG_WADDR,
  output logic [13:0] PROG_WDATA
);
  localparam logic [10:0] PC_MASK = 11'(PROG_DEPTH - 1);

  core_pkg::core_state_t state_q;
  core_pkg::iclass_t cls;
  core_pkg::alu_op_t op;
  core_pkg::alu_res_t res;
  core_pkg::prog_pins_t sync1_q, sync2_q, sync3_q;
  logic [5:0] div_q;
  logic [10:0] pc_q, tgt;
  logic [13:0] ir_q, shift_q;
  logic [7:0] w_q, fsr_q, pclath_q, fval, opb, wr_val, bitv;
  logic [2:0] flags_q;
  logic [3:0] pcnt_q;
  logic [6:0] ea;
  logic [7:0] dmem [0:127];
  logic step, exec, brk, wr_f, wr_w, flg_en, pclk_rise, wr_q;

  // special function registers are not backed by the array
  function automatic logic is_sfr(input logic [6:0] a);
    return a == `ADDR_INDF || a == `ADDR_PCL || a == `ADDR_STATUS ||
           a == `ADDR_FSR || a == `ADDR_PCLATH;
  endfunction

  function automatic core_pkg::alu_res_t alu(input core_pkg::alu_op_t o,
      input logic [7:0] a, input logic [7:0] b, input logic cin);
    core_pkg::alu_res_t r;
    logic [8:0] s;
    logic [4:0] n;
    r = '{val: b, c: cin, nc: 1'b0, upd_c: 1'b0, upd_nc: 1'b0,
          upd_z: 1'b1};
    s = 9'h000;
    n = 5'h00;
    unique case (o)
      core_pkg::OP_ADD: begin
        s = {1'b0, a} + {1'b0, b};
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      end
      // carry out of b + ~a + 1 is 1 when no borrow occurred
      core_pkg::OP_SUB: begin
        s = {1'b0, b} + {1'b0, ~a} + 9'h001;
        n = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
      end
      core_pkg::OP_AND: r.val = a & b;
      core_pkg::OP_IOR: r.val = a | b;
      core_pkg::OP_XOR: r.val = a ^ b;
      core_pkg::OP_MOV: r.val = b;
      core_pkg::OP_COM: r.val = ~b;
      core_pkg::OP_INC: r.val = b + 8'h01;
      core_pkg::OP_DEC: r.val = b - 8'h01;
      core_pkg::OP_RLF: r = '{{b[6:0], cin}, b[7], 1'b0, 1'b1, 1'b0, 1'b0};
      core_pkg::OP_RRF: r = '{{cin, b[7:1]}, b[0], 1'b0, 1'b1, 1'b0, 1'b0};
      core_pkg::OP_SWAP: begin
        r.val = {b[3:0], b[7:4]};
        r.upd_z = 1'b0;
      end
      core_pkg::OP_CLR: r.val = 8'h00;
      core_pkg::OP_MOVW: begin
        r.val = a;
        r.upd_z = 1'b0;
      end
      default: r.upd_z = 1'b0; // spare codes pass b untouched
    endcase
    if (o == core_pkg::OP_ADD || o == core_pkg::OP_SUB) begin
      r = '{s[7:0], s[8], n[4], 1'b1, 1'b1, 1'b1};
    end
    return r;
  endfunction

  // instruction cycle divider: 40 reference clocks per instruction
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) div_q <= 6'h00;
    else if (step) div_q <= 6'h00;
    else div_q <= div_q + 6'h01;
  end
  assign step = div_q == 6'(`INSTR_CYCLES - 1);
  assign exec = step && state_q == core_pkg::S_RUN;

  // decode and operand selection for the word in the execute stage
  always_comb begin
    cls = core_pkg::iclass_t'(ir_q[13:12]);
    op = core_pkg::alu_op_t'(ir_q[11:8]);
    ea = (ir_q[6:0] == `ADDR_INDF) ? fsr_q[6:0] : ir_q[6:0];
    unique case (ea)
      `ADDR_INDF: fval = 8'h00;
      `ADDR_PCL: fval = pc_q[7:0];
      `ADDR_STATUS: fval = {5'h00, flags_q};
      `ADDR_FSR: fval = fsr_q;
      `ADDR_PCLATH: fval = pclath_q;
      default: fval = dmem[ea];
    endcase
    opb = (cls == core_pkg::IC_LIT) ? ir_q[7:0] : fval;
    res = alu(op, w_q, opb, flags_q[`FLAG_C]);
    bitv = fval;
    bitv[ir_q[9:7]] = ir_q[10];
    wr_f = 1'b0;
    wr_w = 1'b0;
    wr_val = res.val;
    brk = 1'b0;
    tgt = 11'(pc_q + 11'h001) & PC_MASK;
    unique case (cls)
      core_pkg::IC_FILE: begin
        wr_f = ir_q[7];
        wr_w = !ir_q[7];
      end
      core_pkg::IC_LIT: wr_w = 1'b1;
      core_pkg::IC_GOTO: begin
        brk = 1'b1;
        tgt = ir_q[10:0] & PC_MASK;
      end
      core_pkg::IC_BIT: begin
        if (!ir_q[11]) begin
          wr_f = 1'b1;
          wr_val = bitv;
        end else begin
          brk = fval[ir_q[9:7]] == ir_q[10]; // skip costs a flush
        end
      end
    endcase
    // writing the low pc byte is a computed jump
    if (wr_f && ea == `ADDR_PCL) begin
      brk = 1'b1;
      tgt = {pclath_q[2:0], wr_val} & PC_MASK;
    end
    flg_en = exec && (cls == core_pkg::IC_FILE || cls == core_pkg::IC_LIT)
      && !(wr_f && ea == `ADDR_STATUS);
  end

  // fetch/execute pipeline; a branch drops the prefetched word
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= core_pkg::S_FILL;
      pc_q <= `PC_RESET;
      ir_q <= 14'h0000;
    end else if (sync2_q.mode) begin
      state_q <= core_pkg::S_PROG;
      pc_q <= `PC_RESET;
    end else if (step) begin
      unique case (state_q)
        core_pkg::S_RUN: begin
          if (brk) begin
            state_q <= core_pkg::S_FLUSH;
            pc_q <= tgt;
          end else begin
            ir_q <= PM_DATA;
            pc_q <= 11'(pc_q + 11'h001) & PC_MASK;
          end
        end
        core_pkg::S_FILL, core_pkg::S_FLUSH: begin
          state_q <= core_pkg::S_RUN;
          ir_q <= PM_DATA;
          pc_q <= 11'(pc_q + 11'h001) & PC_MASK;
        end
        core_pkg::S_PROG: begin
          state_q <= core_pkg::S_FILL;
          pc_q <= `PC_RESET;
        end
        default: state_q <= core_pkg::S_FILL;
      endcase
    end
  end

  // working register has no data address; only alu results land here
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) w_q <= `W_RESET;
    else if (exec && wr_w) w_q <= res.val;
  end

  // status: an explicit write to status suppresses the alu flag updates of that instruction
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      flags_q <= `FLAGS_RESET;
    end else if (exec) begin
      if (wr_f && ea == `ADDR_STATUS) flags_q <= wr_val[2:0];
      if (flg_en && res.upd_c) flags_q[`FLAG_C] <= res.c;
      if (flg_en && res.upd_nc) flags_q[`FLAG_NC] <= res.nc;
      if (flg_en && res.upd_z) flags_q[`FLAG_Z] <= res.val == 8'h00;
    end
  end

  // pointer and page latch sfrs
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      fsr_q <= `FSR_RESET;
      pclath_q <= `PCLATH_RESET;
    end else if (exec && wr_f) begin
      if (ea == `ADDR_FSR) fsr_q <= wr_val;
      if (ea == `ADDR_PCLATH) pclath_q <= wr_val;
    end
  end

  // general file registers; no reset, contents are undefined at power-up
  always_ff @(posedge REF_CLK) begin
    if (exec && wr_f && !is_sfr(ea)) dmem[ea] <= wr_val;
  end

  // pin synchronisers; the second stage feeds logic, the third only the clock edge detect
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= '{PROG_MODE, PROG_CLOCK_PIN, PROG_DATA_PIN_I};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  assign pclk_rise = sync2_q.clk && !sync3_q.clk;

  // serial loader: data sampled on programmer clock rising edge, lsb first
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      shift_q <= 14'h0000;
      pcnt_q <= 4'h0;
      wr_q <= 1'b0;
      PROG_WDATA <= 14'h0000;
      PROG_WADDR <= 11'h000;
    end else begin
      wr_q <= 1'b0;
      if (state_q != core_pkg::S_PROG) begin
        pcnt_q <= 4'h0;
        PROG_WADDR <= 11'h000;
      end else if (wr_q) begin
        PROG_WADDR <= 11'(PROG_WADDR + 11'h001) & PC_MASK;
      end else if (pclk_rise) begin
        shift_q <= {sync2_q.data, shift_q[13:1]};
        if (pcnt_q == 4'(`PROG_WORD_BITS - 1)) begin
          pcnt_q <= 4'h0;
          wr_q <= 1'b1;
          PROG_WDATA <= {sync2_q.data, shift_q[13:1]};
        end else begin
          pcnt_q <= pcnt_q + 4'h1;
        end
      end
    end
  end

  assign PM_ADDR = pc_q;
  assign INSTR_STEP = step;
  assign W_VALUE = w_q;
  assign FLAGS = flags_q;
  assign PROG_WR = wr_q;
  assign PROG_DATA_PIN_O = 1'b0; // loader only listens
  assign PROG_DATA_PIN_OE_N = 1'b1;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  chk_fetch_word: assert property (exec && !brk && !sync2_q.mode |=>
    ir_q == $past(PM_DATA))
    else $error("fetched word not taken into execute stage");
  chk_pc_advance: assert property (exec && !brk && !sync2_q.mode |=>
    pc_q == (11'($past(pc_q) + 11'h001) & PC_MASK))
    else $error("fetch address did not advance");
  chk_step_period: assert property (step |-> ##40 step)
    else $error("instruction cycle is not 40 clocks");
  // entering programming mode legally cuts the flush short
  chk_branch_flush: assert property (
    disable iff (!NRST || sync2_q.mode)
    exec && brk && !sync2_q.mode |=>
    state_q == core_pkg::S_FLUSH ##40 state_q == core_pkg::S_RUN)
    else $error("branch did not spend one flush cycle");
  chk_pc_range: assert property (12'(pc_q) < 12'(PROG_DEPTH))
    else $error("pc beyond program memory");
  chk_sub_borrow: assert property (flg_en && op == core_pkg::OP_SUB |=>
    FLAGS[`FLAG_C] == ($past(opb) >= $past(w_q)))
    else $error("carry does not reflect borrow on subtract");
  chk_zero_flag: assert property (flg_en && res.upd_z |=>
    FLAGS[`FLAG_Z] == ($past(res.val) == 8'h00))
    else $error("zero flag wrong");
  chk_w_dest: assert property (exec && wr_w |=> W_VALUE == $past(res.val))
    else $error("w not loaded with result");
  chk_prog_word: assert property (PROG_WR |-> state_q == core_pkg::S_PROG)
    else $error("program word outside programming mode");

  cov_branch: cover property (exec && brk ##1 state_q == core_pkg::S_FLUSH);
  cov_subtract: cover property (flg_en && op == core_pkg::OP_SUB);
  cov_prog_word: cover property (PROG_WR);
endmodule

// ===== bench/tb_top.sv
// bench for harvard_core: runs short programs and a serial word load
// assumes the core reads program words through a combinational memory
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, nrst, prog_mode, prog_clk, prog_din;
  logic prog_dout, prog_oe_n, prog_wr, instr_step;
  logic [10:0] pm_addr, prog_waddr;
  logic [13:0] pm_data, prog_wdata;
  logic [13:0] mem [0:2047];
  logic [7:0] w_value;
  logic [2:0] flags;
  logic [21:0] stepq [$];
  logic [24:0] progq [$];
  int errors, compares, gap;

  harvard_core i_harvard_core (.REF_CLK(ref_clk), .NRST(nrst),
    .PM_ADDR(pm_addr), .PM_DATA(pm_data), .INSTR_STEP(instr_step),
    .W_VALUE(w_value), .FLAGS(flags), .PROG_MODE(prog_mode),
    .PROG_CLOCK_PIN(prog_clk), .PROG_DATA_PIN_I(prog_din),
    .PROG_DATA_PIN_O(prog_dout), .PROG_DATA_PIN_OE_N(prog_oe_n),
    .PROG_WR(prog_wr), .PROG_WADDR(prog_waddr), .PROG_WDATA(prog_wdata));

  // program memory answers within the same cycle
  assign pm_data = mem[pm_addr];

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // clocks since the last instruction boundary
  always @(posedge ref_clk) gap <= (!nrst || instr_step) ? 0 : gap + 1;

  task automatic check(string what, logic [24:0] exp, logic [24:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // step watcher: look one settle time after the boundary edge
  initial begin
    logic [21:0] e;
    forever begin
      @(negedge ref_clk);
      if (instr_step === 1'b1 && stepq.size() > 0) begin
        e = stepq.pop_front();
        check("step gap", 25'd39, 25'(gap));
        @(posedge ref_clk);
        #1;
        check("pc", 25'(e[21:11]), 25'(pm_addr));
        check("w", 25'(e[10:3]), 25'(w_value));
        check("flags", 25'(e[2:0]), 25'(flags));
      end
    end
  end

  // serial load watcher
  initial begin
    logic [24:0] e;
    forever begin
      @(negedge ref_clk);
      if (prog_wr === 1'b1) begin
        e = progq.size() ? progq.pop_front() : 25'h1ff_ffff;
        check("prog word", e, {prog_waddr, prog_wdata});
        check("data pin oe_n", 25'h1, 25'(prog_oe_n));
        check("data pin out", 25'h0, 25'(prog_dout));
      end
    end
  end

  // bounded wait until every note has been consumed
  task automatic wait_drain();
    int t;
    t = 0;
    while ((stepq.size() || progq.size()) && t < 1200) begin
      @(posedge ref_clk);
      t++;
    end
    if (t == 1200) begin
      errors++;
      $display("unexpected drain: expected 0, seen %0d", stepq.size());
      tally_and_finish();
    end else repeat (2) @(posedge ref_clk);
  endtask

  task automatic note(logic [10:0] a, logic [7:0] w, logic [2:0] f);
    stepq.push_back({a, w, f});
  endtask

  // reset held low while the program and notes are set up
  task automatic run_prog(logic [7:0] k1, k2, k3, k4);
    logic [8:0] s;
    logic [7:0] r, m, p, q;
    logic c, n;
    @(posedge ref_clk);
    #1 nrst = 1'b0;
    s = k1 + k2;
    r = k3 - s[7:0];
    c = k3 >= s[7:0];
    n = k3[3:0] >= s[3:0];
    m = ~k4;
    p = k4 + 8'h01;
    q = {k4[6:0], c};
    mem[0] = {2'h1, 4'h5, k1};
    mem[1] = {2'h1, 4'h0, k2};
    mem[2] = {2'h1, 4'h1, k3};
    mem[3] = {2'h1, 4'h4, r};
    mem[4] = 14'h2006;
    mem[5] = {2'h1, 4'h5, 8'hff}; // discarded by the branch
    mem[6] = {2'h1, 4'h3, k4};
    mem[7] = {2'h0, 4'hd, 1'b1, 7'h20};
    mem[8] = {2'h0, 4'h6, 1'b0, 7'h20};
    mem[9] = {2'h1, 4'h5, 8'h20};
    mem[10] = {2'h0, 4'hd, 1'b1, 7'h04}; // w into the pointer
    mem[11] = {2'h0, 4'h7, 1'b0, 7'h00}; // increment through pointer
    mem[12] = {2'h0, 4'h9, 1'b0, 7'h20}; // rotate left through carry
    mem[13] = {2'h3, 2'h0, 3'h2, 7'h03}; // clear the zero flag
    mem[14] = {2'h3, 2'h2, 3'h2, 7'h03}; // skip, zero flag is clear
    mem[15] = {2'h1, 4'h5, 8'hff}; // skipped
    mem[16] = 14'h2010;
    note(11'h001, 8'h00, 3'h0);
    note(11'h002, k1, {k1 == 0, 2'b00});
    note(11'h003, s[7:0], {s[7:0] == 0, k1[3:0] + k2[3:0] > 15, s[8]});
    note(11'h004, r, {r == 0, n, c});
    note(11'h005, 8'h00, {1'b1, n, c});
    note(11'h006, 8'h00, {1'b1, n, c});
    note(11'h007, 8'h00, {1'b1, n, c});
    note(11'h008, k4, {k4 == 0, n, c});
    note(11'h009, k4, {k4 == 0, n, c});
    note(11'h00a, m, {m == 0, n, c});
    note(11'h00b, 8'h20, {1'b0, n, c});
    note(11'h00c, 8'h20, {1'b0, n, c});
    note(11'h00d, p, {p == 0, n, c});
    note(11'h00e, q, {p == 0, n, k4[7]});
    note(11'h00f, q, {1'b0, n, k4[7]});
    note(11'h010, q, {1'b0, n, k4[7]});
    note(11'h011, q, {1'b0, n, k4[7]});
    note(11'h010, q, {1'b0, n, k4[7]});
    repeat (2) @(posedge ref_clk);
    #1 nrst = 1'b1;
    wait_drain();
  endtask

  task automatic send_word(logic [10:0] a, logic [13:0] d);
    progq.push_back({a, d});
    for (int i = 0; i < 14; i++) begin
      @(posedge ref_clk);
      #1 prog_din = d[i]; // lsb first
      repeat (5) @(posedge ref_clk);
      #1 prog_clk = 1'b1;
      repeat (5) @(posedge ref_clk);
      #1 prog_clk = 1'b0;
    end
  endtask

  initial begin
    nrst = 1'b0;
    prog_mode = 1'b0;
    prog_clk = 1'b0;
    prog_din = 1'b0;
    foreach (mem[i]) mem[i] = 14'h2000;
    void'($urandom(42216));
    repeat (2) @(posedge ref_clk);
    #1 nrst = 1'b1;
    run_prog(8'hff, 8'h01, 8'h00, 8'h00); // carry, nibble carry, zero
    run_prog(8'h0f, 8'h01, 8'h05, 8'hff);
    repeat (6) run_prog(8'($urandom), 8'($urandom), 8'($urandom),
      8'($urandom));
    // serial load: two words, addresses counted from zero
    @(posedge ref_clk);
    #1 prog_mode = 1'b1;
    repeat (4) @(posedge ref_clk);
    send_word(11'h000, 14'($urandom));
    send_word(11'h001, 14'h3fff);
    wait_drain();
    #1 prog_mode = 1'b0;
    run_prog(8'h80, 8'h80, 8'hff, 8'h5a);
    tally_and_finish();
  end
endmodule
